// file: rtl/pcfg_regs.sv
`timescale 1ns/100ps
`include "pcfg_consts.svh"
module pcfg_regs #(
	parameter logic [7:0] CHIP_ID_VALUE = 8'h5A,  // Arbitrary value
	parameter logic [7:0] REV_ID_VALUE  = 8'h01   // Arbitrary value
) (
	input  wire logic        REF_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        CLK_EN,
	input  wire logic        ACTIVATION_STRAP,
	input  wire logic        CFG_WR,
	input  wire logic        CFG_RD,
	input  wire logic        CFG_PORT_SEL,
	input  wire logic [7:0]  CFG_WDATA,
	output logic      [7:0]  CFG_RDATA,
	input  wire logic        KBD_PWR_FN_EN,
	input  wire logic        CLK_PWR_FN_EN,
	input  wire logic        KBD_IRQ_REQ,
	input  wire logic        MOUSE_IRQ_REQ,
	output logic             KEYBOARD_IRQ_OUTPUT,
	output logic             MOUSE_IRQ_OUTPUT,
	output logic             KBD_ENABLE,
	output logic             MOUSE_ENABLE,
	output logic             CLK_ENABLE,
	output logic             CLOCK_POWER_CONTROL_EN,
	input  wire logic        IO_RD,
	input  wire logic [15:0] IO_ADDR,
	output logic             RANGE_VALID,
	output logic      [15:0] RANGE_DATA
);
	localparam int CS_ENTRIES = 8;

	pcfg_pkg::pcfg_byte_t index_reg, index_next, ldn_reg, ldn_next, card_reg, card_next;
	pcfg_pkg::pcfg_byte_t gcfg1_reg, gcfg1_next, gcfg2_reg, gcfg2_next, csidx_reg, csidx_next;
	pcfg_pkg::pcfg_byte_t cs_mem_reg [CS_ENTRIES];
	pcfg_pkg::pcfg_byte_t cs_mem_next [CS_ENTRIES];
	pcfg_pkg::pcfg_byte_t kact_reg, kact_next, mact_reg, mact_next, cact_reg, cact_next;
	pcfg_pkg::pcfg_byte_t krc_reg, krc_next, crc_reg, crc_next;
	pcfg_pkg::pcfg_byte_t kbh_reg, kbh_next, kbl_reg, kbl_next, kch_reg, kch_next, kcl_reg, kcl_next;
	pcfg_pkg::pcfg_byte_t cbh_reg, cbh_next, cbl_reg, cbl_next;
	pcfg_pkg::pcfg_byte_t kis_reg, kis_next, mis_reg, mis_next, cis_reg, cis_next;
	pcfg_pkg::pcfg_byte_t kit_reg, kit_next, mit_reg, mit_next, cit_reg, cit_next;
	pcfg_pkg::pcfg_byte_t kdev_reg, kdev_next, rdata_reg, rdata_next;
	logic                 strap_done_reg, strap_done_next;
	logic                 rvalid_reg, rvalid_next;
	logic [15:0]          rdata16_reg, rdata16_next;
	logic                 data_wr, data_rd, soft_rst;
	pcfg_pkg::pcfg_byte_t strap_act, rd_val;

	assign data_wr   = CFG_WR && (CFG_PORT_SEL == pcfg_pkg::PCFG_PORT_DATA);
	assign data_rd   = CFG_RD && (CFG_PORT_SEL == pcfg_pkg::PCFG_PORT_DATA);
	assign soft_rst  = data_wr && (index_reg == `PCFG_IDX_CFG_CTRL) && CFG_WDATA[`PCFG_SOFT_RST_BIT];
	assign strap_act = {7'h00, ACTIVATION_STRAP};

	// Register bank next values
	always_comb begin
		index_next = index_reg;
		ldn_next   = ldn_reg;
		card_next  = card_reg;
		gcfg1_next = gcfg1_reg;
		gcfg2_next = gcfg2_reg;
		csidx_next = csidx_reg;
		for (int i = 0; i < CS_ENTRIES; i++) begin
			cs_mem_next[i] = cs_mem_reg[i];
		end
		kact_next = kact_reg;
		mact_next = mact_reg;
		cact_next = cact_reg;
		krc_next  = krc_reg;
		crc_next  = crc_reg;
		kbh_next  = kbh_reg;
		kbl_next  = kbl_reg;
		kch_next  = kch_reg;
		kcl_next  = kcl_reg;
		cbh_next  = cbh_reg;
		cbl_next  = cbl_reg;
		kis_next  = kis_reg;
		mis_next  = mis_reg;
		cis_next  = cis_reg;
		kit_next  = kit_reg;
		mit_next  = mit_reg;
		cit_next  = cit_reg;
		kdev_next = kdev_reg;
		strap_done_next = 1'b1;
		// strap caught after hard reset release
		if (!strap_done_reg) begin
			kact_next = strap_act;
			cact_next = strap_act;
		end
		if (CFG_WR && (CFG_PORT_SEL == pcfg_pkg::PCFG_PORT_INDEX)) begin
			index_next = CFG_WDATA;
		end
		if (soft_rst) begin
			kact_next = strap_act;
			cact_next = strap_act;
			mact_next = `PCFG_RST_ZERO;
			krc_next  = `PCFG_RST_ZERO;
			crc_next  = `PCFG_RST_ZERO;
			kbh_next  = `PCFG_RST_ZERO;
			kbl_next  = `PCFG_RST_KBD_LO;
			kch_next  = `PCFG_RST_ZERO;
			kcl_next  = `PCFG_RST_KBD_CMD_LO;
			cbh_next  = `PCFG_RST_ZERO;
			cbl_next  = `PCFG_RST_CLK_LO;
			kis_next  = `PCFG_RST_KBD_IRQ;
			mis_next  = `PCFG_RST_MOUSE_IRQ;
			cis_next  = `PCFG_RST_CLK_IRQ;
			kit_next  = `PCFG_RST_KM_TYPE;
			mit_next  = `PCFG_RST_KM_TYPE;
			cit_next  = `PCFG_RST_CLK_TYPE;
			ldn_next  = `PCFG_RST_ZERO;
		end
		// card number cleared by its own control bit
		if (data_wr && (index_reg == `PCFG_IDX_CFG_CTRL) && CFG_WDATA[`PCFG_CARD_CLR_BIT]) begin
			card_next = `PCFG_RST_ZERO;
		end
		if (data_wr && !soft_rst) begin
			unique case (index_reg)
				`PCFG_IDX_CARD_NUM: card_next  = CFG_WDATA;
				`PCFG_IDX_LDN:      ldn_next   = CFG_WDATA;
				`PCFG_IDX_GCFG1:    gcfg1_next = CFG_WDATA;
				`PCFG_IDX_GCFG2:    gcfg2_next = CFG_WDATA;
				`PCFG_IDX_CS_INDEX: csidx_next = CFG_WDATA;
				`PCFG_IDX_CS_DATA:  cs_mem_next[csidx_reg[2:0]] = CFG_WDATA;
				default: begin
					unique case (ldn_reg)
						`PCFG_LDN_KBD: begin
							unique case (index_reg)
								`PCFG_IDX_ACTIVATE: kact_next = CFG_WDATA & 8'h01;
								`PCFG_IDX_RANGE:    krc_next  = CFG_WDATA & `PCFG_RANGE_MASK;
								`PCFG_IDX_BASE_HI:  kbh_next  = CFG_WDATA;
								`PCFG_IDX_BASE_LO:  kbl_next  = CFG_WDATA & 8'hFB;
								`PCFG_IDX_CMD_HI:   kch_next  = CFG_WDATA;
								`PCFG_IDX_CMD_LO:   kcl_next  = CFG_WDATA | 8'h04;
								`PCFG_IDX_IRQ_SEL:  kis_next  = CFG_WDATA;
								`PCFG_IDX_IRQ_TYPE: kit_next  = CFG_WDATA & `PCFG_KM_TYPE_MASK;
								`PCFG_IDX_DEV_CFG:  kdev_next = CFG_WDATA;
								default: ;
							endcase
						end
						`PCFG_LDN_MOUSE: begin
							unique case (index_reg)
								`PCFG_IDX_ACTIVATE: mact_next = CFG_WDATA & 8'h01;
								`PCFG_IDX_IRQ_SEL:  mis_next  = CFG_WDATA;
								`PCFG_IDX_IRQ_TYPE: mit_next  = CFG_WDATA & `PCFG_KM_TYPE_MASK;
								default: ;
							endcase
						end
						`PCFG_LDN_CLOCK: begin
							unique case (index_reg)
								`PCFG_IDX_ACTIVATE: cact_next = CFG_WDATA & 8'h01;
								`PCFG_IDX_RANGE:    crc_next  = CFG_WDATA & `PCFG_RANGE_MASK;
								`PCFG_IDX_BASE_HI:  cbh_next  = CFG_WDATA;
								`PCFG_IDX_BASE_LO:  cbl_next  = CFG_WDATA & 8'hFE;
								`PCFG_IDX_IRQ_SEL:  cis_next  = CFG_WDATA;
								`PCFG_IDX_IRQ_TYPE: cit_next  = CFG_WDATA & `PCFG_CLK_TYPE_MASK;
								default: ;
							endcase
						end
						default: ;
					endcase
				end
			endcase
		end
	end

	// Read mux for the data port
	always_comb begin
		rd_val = `PCFG_RST_ZERO;
		unique case (index_reg)
			`PCFG_IDX_CARD_NUM: rd_val = card_reg;
			`PCFG_IDX_LDN:      rd_val = ldn_reg;
			`PCFG_IDX_CHIP_ID:  rd_val = CHIP_ID_VALUE;
			`PCFG_IDX_GCFG1:    rd_val = gcfg1_reg;
			`PCFG_IDX_GCFG2:    rd_val = gcfg2_reg;
			`PCFG_IDX_CS_INDEX: rd_val = csidx_reg;
			`PCFG_IDX_CS_DATA:  rd_val = cs_mem_reg[csidx_reg[2:0]];
			`PCFG_IDX_REV_ID:   rd_val = REV_ID_VALUE;
			default: begin
				unique case (ldn_reg)
					`PCFG_LDN_KBD: begin
						unique case (index_reg)
							`PCFG_IDX_ACTIVATE: rd_val = kact_reg;
							`PCFG_IDX_RANGE:    rd_val = krc_reg;
							`PCFG_IDX_BASE_HI:  rd_val = kbh_reg;
							`PCFG_IDX_BASE_LO:  rd_val = kbl_reg;
							`PCFG_IDX_CMD_HI:   rd_val = kch_reg;
							`PCFG_IDX_CMD_LO:   rd_val = kcl_reg;
							`PCFG_IDX_IRQ_SEL:  rd_val = kis_reg;
							`PCFG_IDX_IRQ_TYPE: rd_val = kit_reg;
							`PCFG_IDX_DMA0, `PCFG_IDX_DMA1: rd_val = `PCFG_NO_DMA;
							`PCFG_IDX_DEV_CFG:  rd_val = kdev_reg;
							default: ;
						endcase
					end
					`PCFG_LDN_MOUSE: begin
						unique case (index_reg)
							`PCFG_IDX_ACTIVATE: rd_val = mact_reg;
							`PCFG_IDX_IRQ_SEL:  rd_val = mis_reg;
							`PCFG_IDX_IRQ_TYPE: rd_val = mit_reg;
							`PCFG_IDX_DMA0, `PCFG_IDX_DMA1: rd_val = `PCFG_NO_DMA;
							default: ;
						endcase
					end
					`PCFG_LDN_CLOCK: begin
						unique case (index_reg)
							`PCFG_IDX_ACTIVATE: rd_val = cact_reg;
							`PCFG_IDX_RANGE:    rd_val = crc_reg;
							`PCFG_IDX_BASE_HI:  rd_val = cbh_reg;
							`PCFG_IDX_BASE_LO:  rd_val = cbl_reg;
							`PCFG_IDX_IRQ_SEL:  rd_val = cis_reg;
							`PCFG_IDX_IRQ_TYPE: rd_val = cit_reg;
							`PCFG_IDX_DMA0, `PCFG_IDX_DMA1: rd_val = `PCFG_NO_DMA;
							default: ;
						endcase
					end
					default: ;
				endcase
			end
		endcase
	end

	// Host read and range-check answer
	always_comb begin
		rdata_next   = rdata_reg;
		rvalid_next  = 1'b0;
		rdata16_next = rdata16_reg;
		if (CFG_RD) begin
			rdata_next = data_rd ? rd_val : index_reg;
		end
		if (IO_RD) begin
			if (krc_reg[`PCFG_RC_EN_BIT] && !kact_reg[`PCFG_ACT_BIT] &&
			    ((IO_ADDR == {kbh_reg, kbl_reg}) || (IO_ADDR == {kch_reg, kcl_reg}))) begin
				rvalid_next  = 1'b1;
				rdata16_next = krc_reg[`PCFG_RC_CTRL_BIT] ? `PCFG_RC_SET : `PCFG_RC_CLR;
			end else if (crc_reg[`PCFG_RC_EN_BIT] && !cact_reg[`PCFG_ACT_BIT] &&
			             (IO_ADDR[15:1] == {cbh_reg, cbl_reg[7:1]})) begin
				rvalid_next  = 1'b1;
				rdata16_next = crc_reg[`PCFG_RC_CTRL_BIT] ? `PCFG_RC_SET : `PCFG_RC_CLR;
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			index_reg <= `PCFG_RST_ZERO;
			ldn_reg   <= `PCFG_RST_ZERO;
			card_reg  <= `PCFG_RST_ZERO;
			gcfg1_reg <= `PCFG_RST_GCFG;
			gcfg2_reg <= `PCFG_RST_GCFG;
			csidx_reg <= `PCFG_RST_GCFG;
			for (int i = 0; i < CS_ENTRIES; i++) begin
				cs_mem_reg[i] <= `PCFG_RST_GCFG;
			end
			kact_reg  <= `PCFG_RST_ZERO;
			mact_reg  <= `PCFG_RST_ZERO;
			cact_reg  <= `PCFG_RST_ZERO;
			krc_reg   <= `PCFG_RST_ZERO;
			crc_reg   <= `PCFG_RST_ZERO;
			kbh_reg   <= `PCFG_RST_ZERO;
			kbl_reg   <= `PCFG_RST_KBD_LO;
			kch_reg   <= `PCFG_RST_ZERO;
			kcl_reg   <= `PCFG_RST_KBD_CMD_LO;
			cbh_reg   <= `PCFG_RST_ZERO;
			cbl_reg   <= `PCFG_RST_CLK_LO;
			kis_reg   <= `PCFG_RST_KBD_IRQ;
			mis_reg   <= `PCFG_RST_MOUSE_IRQ;
			cis_reg   <= `PCFG_RST_CLK_IRQ;
			kit_reg   <= `PCFG_RST_KM_TYPE;
			mit_reg   <= `PCFG_RST_KM_TYPE;
			cit_reg   <= `PCFG_RST_CLK_TYPE;
			kdev_reg  <= `PCFG_RST_GCFG;
			rdata_reg <= `PCFG_RST_ZERO;
			strap_done_reg <= 1'b0;
			rvalid_reg     <= 1'b0;
			rdata16_reg    <= 16'h0000;
		end else if (CLK_EN) begin
			index_reg <= index_next;
			ldn_reg   <= ldn_next;
			card_reg  <= card_next;
			gcfg1_reg <= gcfg1_next;
			gcfg2_reg <= gcfg2_next;
			csidx_reg <= csidx_next;
			cs_mem_reg <= cs_mem_next;
			kact_reg  <= kact_next;
			mact_reg  <= mact_next;
			cact_reg  <= cact_next;
			krc_reg   <= krc_next;
			crc_reg   <= crc_next;
			kbh_reg   <= kbh_next;
			kbl_reg   <= kbl_next;
			kch_reg   <= kch_next;
			kcl_reg   <= kcl_next;
			cbh_reg   <= cbh_next;
			cbl_reg   <= cbl_next;
			kis_reg   <= kis_next;
			mis_reg   <= mis_next;
			cis_reg   <= cis_next;
			kit_reg   <= kit_next;
			mit_reg   <= mit_next;
			cit_reg   <= cit_next;
			kdev_reg  <= kdev_next;
			rdata_reg <= rdata_next;
			strap_done_reg <= strap_done_next;
			rvalid_reg     <= rvalid_next;
			rdata16_reg    <= rdata16_next;
		end
	end

	assign CFG_RDATA   = rdata_reg;
	assign RANGE_VALID = rvalid_reg;
	assign RANGE_DATA  = rdata16_reg;
	// bit 0 enables, gated by power functions
	assign KBD_ENABLE  = kact_reg[`PCFG_ACT_BIT] && KBD_PWR_FN_EN;
	// gates only the mouse interrupt, not command handling
	assign MOUSE_ENABLE = mact_reg[`PCFG_ACT_BIT];
	assign CLK_ENABLE  = cact_reg[`PCFG_ACT_BIT] && CLK_PWR_FN_EN;
	assign CLOCK_POWER_CONTROL_EN = CLK_PWR_FN_EN;
	// keyboard interrupt, idle level per polarity
	assign KEYBOARD_IRQ_OUTPUT = (KBD_ENABLE && (kis_reg[3:0] != 4'h0) && KBD_IRQ_REQ) ~^ kit_reg[`PCFG_POL_BIT];
	// mouse interrupt held idle while inactive
	assign MOUSE_IRQ_OUTPUT = (MOUSE_ENABLE && (mis_reg[3:0] != 4'h0) && MOUSE_IRQ_REQ) ~^ mit_reg[`PCFG_POL_BIT];

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	property p_soft_rst_irq;
		(soft_rst && CLK_EN) |=> (kis_reg == `PCFG_RST_KBD_IRQ) && (mis_reg == `PCFG_RST_MOUSE_IRQ);
	endproperty
	a_soft_rst_irq: assert property (p_soft_rst_irq) else $error("soft reset missed irq select");
	property p_gcfg_kept;
		(soft_rst && CLK_EN) |=> (gcfg1_reg == $past(gcfg1_reg)) && (gcfg2_reg == $past(gcfg2_reg));
	endproperty
	a_gcfg_kept: assert property (p_gcfg_kept) else $error("global config lost on soft reset");
	property p_kbd_lo_bit;
		kbl_reg[`PCFG_KBD_RO_BIT] == 1'b0;
	endproperty
	a_kbd_lo_bit: assert property (p_kbd_lo_bit) else $error("keyboard base bit 2 set");
	property p_kbd_cmd_bit;
		kcl_reg[`PCFG_KBD_RO_BIT] == 1'b1;
	endproperty
	a_kbd_cmd_bit: assert property (p_kbd_cmd_bit) else $error("command base bit 2 clear");
	property p_clk_lo_bit;
		cbl_reg[`PCFG_CLK_RO_BIT] == 1'b0;
	endproperty
	a_clk_lo_bit: assert property (p_clk_lo_bit) else $error("clock base bit 0 set");
	property p_mouse_quiet;
		!mact_reg[`PCFG_ACT_BIT] |-> (MOUSE_IRQ_OUTPUT == !mit_reg[`PCFG_POL_BIT]);
	endproperty
	a_mouse_quiet: assert property (p_mouse_quiet) else $error("inactive mouse interrupt asserted");
	property p_no_dma;
		(data_rd && CLK_EN && ldn_reg <= `PCFG_LDN_CLOCK &&
		 (index_reg == `PCFG_IDX_DMA0 || index_reg == `PCFG_IDX_DMA1)) |=> (CFG_RDATA == `PCFG_NO_DMA);
	endproperty
	a_no_dma: assert property (p_no_dma) else $error("DMA select not 04h");
	property p_act_strap;
		(soft_rst && CLK_EN) |=> (kact_reg == {7'h00, $past(ACTIVATION_STRAP)}) && (cact_reg == kact_reg);
	endproperty
	a_act_strap: assert property (p_act_strap) else $error("activate not strap after soft reset");
	property p_type_bits;
		((kit_reg & ~`PCFG_KM_TYPE_MASK) == 8'h00) && ((cit_reg & ~`PCFG_CLK_TYPE_MASK) == 8'h00);
	endproperty
	a_type_bits: assert property (p_type_bits) else $error("read-only type bits set");
	property p_range_ans;
		RANGE_VALID |-> (RANGE_DATA == `PCFG_RC_SET || RANGE_DATA == `PCFG_RC_CLR) && $past(IO_RD);
	endproperty
	a_range_ans: assert property (p_range_ans) else $error("bad range check answer");
endmodule // pcfg_regs

// file: pkg/pcfg_consts.svh
`ifndef PCFG_CONSTS_SVH
`define PCFG_CONSTS_SVH
// Card-level indices
`define PCFG_IDX_RD_PORT     8'h00
`define PCFG_IDX_ISOLATE     8'h01
`define PCFG_IDX_CFG_CTRL    8'h02
`define PCFG_IDX_WAKE        8'h03
`define PCFG_IDX_RES_DATA    8'h04
`define PCFG_IDX_STATUS      8'h05
`define PCFG_IDX_CARD_NUM    8'h06
`define PCFG_IDX_LDN         8'h07
`define PCFG_IDX_CHIP_ID     8'h20
`define PCFG_IDX_GCFG1       8'h21
`define PCFG_IDX_GCFG2       8'h22
`define PCFG_IDX_CS_INDEX    8'h23
`define PCFG_IDX_CS_DATA     8'h24
`define PCFG_IDX_REV_ID      8'h27
// Logical-device indices
`define PCFG_IDX_ACTIVATE    8'h30
`define PCFG_IDX_RANGE       8'h31
`define PCFG_IDX_BASE_HI     8'h60
`define PCFG_IDX_BASE_LO     8'h61
`define PCFG_IDX_CMD_HI      8'h62
`define PCFG_IDX_CMD_LO      8'h63
`define PCFG_IDX_IRQ_SEL     8'h70
`define PCFG_IDX_IRQ_TYPE    8'h71
`define PCFG_IDX_DMA0        8'h74
`define PCFG_IDX_DMA1        8'h75
`define PCFG_IDX_DEV_CFG     8'hF0
// Logical device numbers
`define PCFG_LDN_KBD         8'h00
`define PCFG_LDN_MOUSE       8'h01
`define PCFG_LDN_CLOCK       8'h02
// Field positions
`define PCFG_SOFT_RST_BIT    0
`define PCFG_CARD_CLR_BIT    2
`define PCFG_ACT_BIT         0
`define PCFG_RC_CTRL_BIT     0
`define PCFG_RC_EN_BIT       1
`define PCFG_POL_BIT         1
`define PCFG_KBD_RO_BIT      2
`define PCFG_CLK_RO_BIT      0
// Reset values and masks
`define PCFG_RST_ZERO        8'h00
`define PCFG_RST_KBD_LO      8'h60
`define PCFG_RST_KBD_CMD_LO  8'h64
`define PCFG_RST_KBD_IRQ     8'h01
`define PCFG_RST_MOUSE_IRQ   8'h0C
`define PCFG_RST_CLK_IRQ     8'h08
`define PCFG_RST_KM_TYPE     8'h02
`define PCFG_RST_CLK_TYPE    8'h00
`define PCFG_RST_CLK_LO      8'h70
`define PCFG_RST_GCFG        8'h00
`define PCFG_NO_DMA          8'h04
`define PCFG_KM_TYPE_MASK    8'h03
`define PCFG_CLK_TYPE_MASK   8'h02
`define PCFG_RANGE_MASK      8'h03
`define PCFG_RC_SET          16'h0055
`define PCFG_RC_CLR          16'h00AA
`endif

// file: pkg/pcfg_pkg.sv
package pcfg_pkg;
	// Which configuration port a host access addresses
	typedef enum logic {
		PCFG_PORT_INDEX = 1'b0,
		PCFG_PORT_DATA  = 1'b1
	} pcfg_port_t;
	typedef logic [7:0] pcfg_byte_t;
endpackage

// file: verif/pcfg_host.sv
`timescale 1ns/100ps
`include "pcfg_consts.svh"
module pcfg_host (
	input  wire logic       clk,
	output logic            cfg_wr,
	output logic            cfg_rd,
	output logic            cfg_sel,
	output logic      [7:0] cfg_wdata,
	input  wire logic [7:0] cfg_rdata
);
	initial begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_sel = 1'b0;
		cfg_wdata = 8'h00;
	end
	// One-cycle strobes launched on the falling edge
	task automatic port_wr(input logic sel, input logic [7:0] d);
		@(negedge clk);
		cfg_wr = 1'b1;
		cfg_sel = sel;
		cfg_wdata = d;
		@(negedge clk);
		cfg_wr = 1'b0;
		cfg_wdata = ~d;
	endtask
	task automatic port_rd(input logic sel, output logic [7:0] d);
		@(negedge clk);
		cfg_rd = 1'b1;
		cfg_sel = sel;
		@(negedge clk);
		cfg_rd = 1'b0;
		d = cfg_rdata;
	endtask
	task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
		port_wr(1'b0, idx);
		port_wr(1'b1, d);
	endtask
	task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
		port_wr(1'b0, idx);
		port_rd(1'b1, d);
	endtask
	task automatic dev_sel(input logic [7:0] ldn);
		reg_wr(`PCFG_IDX_LDN, ldn);
	endtask
endmodule // pcfg_host

// file: verif/tb_pcfg_regs.sv
`timescale 1ns/100ps
module tb_pcfg_regs;
	localparam logic [7:0] CID = 8'hA5;  // Arbitrary value
	localparam logic [7:0] RID = 8'h3C;  // Arbitrary value
	logic        ref_clk, sys_rst, clk_en, strap, cfg_wr, cfg_rd, cfg_sel;
	logic [7:0]  cfg_wdata, cfg_rdata;
	logic        kpwr, cpwr, kreq, mreq, kbd_irq, mouse_irq, kbd_en, mouse_en, clk_en_o, clock_power_control;
	logic        io_rd, rng_valid;
	logic [15:0] io_addr, rng_data;
	int          error_cnt = 0;
	int          checked = 0;
	int          cyc = 0;
	int          mdl [3][256];
	int          idx_q [$] = '{8'h30, 8'h31, 8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h71, 8'h74, 8'h75, 8'hF0};
	logic [7:0]  cq [5] = '{8'h06, 8'h21, 8'h22, 8'h23, 8'h24};

	pcfg_regs #(.CHIP_ID_VALUE(CID), .REV_ID_VALUE(RID)) i_pcfg_regs (
		.REF_CLK(ref_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en), .ACTIVATION_STRAP(strap),
		.CFG_WR(cfg_wr), .CFG_RD(cfg_rd), .CFG_PORT_SEL(cfg_sel), .CFG_WDATA(cfg_wdata),
		.CFG_RDATA(cfg_rdata), .KBD_PWR_FN_EN(kpwr), .CLK_PWR_FN_EN(cpwr), .KBD_IRQ_REQ(kreq),
		.MOUSE_IRQ_REQ(mreq), .KEYBOARD_IRQ_OUTPUT(kbd_irq), .MOUSE_IRQ_OUTPUT(mouse_irq),
		.KBD_ENABLE(kbd_en), .MOUSE_ENABLE(mouse_en), .CLK_ENABLE(clk_en_o),
		.CLOCK_POWER_CONTROL_EN(clock_power_control), .IO_RD(io_rd), .IO_ADDR(io_addr), .RANGE_VALID(rng_valid),
		.RANGE_DATA(rng_data));
	pcfg_host i_pcfg_host (.clk(ref_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_sel(cfg_sel),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_pin(input string n, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %b seen %b", n, e, g);
		end
	endtask
	task automatic chk_rng(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	// Reset and write behaviour of the device registers
	function automatic int rstv(int l, int i);
		case (i)
			8'h30: return (l == 1) ? 0 : strap;
			8'h61: return (l == 0) ? 8'h60 : (l == 2) ? 8'h70 : 0;
			8'h63: return (l == 0) ? 8'h64 : 0;
			8'h70: return (l == 0) ? 8'h01 : (l == 1) ? 8'h0C : 8'h08;
			8'h71: return (l == 2) ? 0 : 8'h02;
			8'h74, 8'h75: return 8'h04;
			default: return 0;
		endcase
	endfunction
	function automatic int nxt(int l, int i, int o, int w);
		case (i)
			8'h30: return w & 1;
			8'h31: return (l == 1) ? 0 : w & 3;
			8'h60: return (l == 1) ? 0 : w;
			8'h61: return (l == 0) ? w & 8'hFB : (l == 2) ? w & 8'hFE : 0;
			8'h62, 8'hF0: return (l == 0) ? w : 0;
			8'h63: return (l == 0) ? w | 4 : 0;
			8'h70: return w;
			8'h71: return (l == 2) ? (o & 8'hFD) | (w & 2) : (o & 8'hFC) | (w & 3);
			default: return o;
		endcase
	endfunction
	function automatic logic irq_exp(logic req, int sel, int typ, logic act);
		return (req && act && sel[3:0] != 0) ? typ[1] : !typ[1];
	endfunction
	task automatic mdl_rst(input logic hard);
		for (int l = 0; l < 3; l++) begin
			foreach (idx_q[k]) begin
				if (hard || idx_q[k] != 8'hF0) mdl[l][idx_q[k]] = rstv(l, idx_q[k]);
			end
		end
	endtask
	task automatic mw(input int l, input int i, input logic [7:0] w);
		i_pcfg_host.dev_sel(8'(l));
		i_pcfg_host.reg_wr(8'(i), w);
		mdl[l][i] = nxt(l, i, mdl[l][i], w);
	endtask
	task automatic check_all();
		logic [7:0] d;
		for (int l = 0; l < 3; l++) begin
			i_pcfg_host.dev_sel(8'(l));
			foreach (idx_q[k]) begin
				i_pcfg_host.reg_rd(8'(idx_q[k]), d);
				chk_reg("dev reg", 8'(mdl[l][idx_q[k]]), d);
			end
		end
	endtask
	task automatic pin_chk();
		for (int n = 0; n < 4; n++) begin
			@(negedge ref_clk);
			{kreq, mreq, kpwr, cpwr} = 4'($urandom);
			#1;
			chk_pin("kbd irq", irq_exp(kreq, mdl[0][8'h70], mdl[0][8'h71], mdl[0][8'h30][0] & kpwr), kbd_irq);
			chk_pin("mouse irq", irq_exp(mreq, mdl[1][8'h70], mdl[1][8'h71], mdl[1][8'h30][0]), mouse_irq);
			chk_pin("kbd en", mdl[0][8'h30][0] & kpwr, kbd_en);
			chk_pin("mouse en", mdl[1][8'h30][0], mouse_en);
			chk_pin("clk en", mdl[2][8'h30][0] & cpwr, clk_en_o);
			chk_pin("clk power", cpwr, clock_power_control);
		end
	endtask
	task automatic io_chk(input logic [15:0] a, input int l, input logic hit);
		logic v;
		@(negedge ref_clk);
		io_rd = 1'b1;
		io_addr = a;
		@(negedge ref_clk);
		io_rd = 1'b0;
		io_addr = ~a;
		v = hit && mdl[l][8'h31][1] && !mdl[l][8'h30][0];
		chk_pin("range valid", v, rng_valid);
		if (v) chk_rng("range data", mdl[l][8'h31][0] ? 16'h0055 : 16'h00AA, rng_data);
	endtask

	initial begin
		logic [7:0] d;
		int cv [5];
		{sys_rst, clk_en, kpwr, cpwr, kreq, mreq, io_rd} = 7'h60;
		io_addr = 16'h0000;
		void'($urandom(32'h4493BE75));
		strap = 1'($urandom);
		sys_rst = 1'b1;
		repeat (8) @(negedge ref_clk);
		sys_rst = 1'b0;
		mdl_rst(1'b1);
		repeat (2) @(negedge ref_clk);
		check_all();
		pin_chk();
		foreach (cq[k]) begin
			i_pcfg_host.reg_rd(cq[k], d);
			chk_reg("card reg", 8'h00, d);
		end
		i_pcfg_host.reg_rd(8'h20, d);
		chk_reg("chip id", CID, d);
		i_pcfg_host.reg_wr(8'h27, ~RID);
		i_pcfg_host.reg_rd(8'h27, d);
		chk_reg("rev id", RID, d);
		for (int l = 0; l < 3; l++) begin
			foreach (idx_q[k]) mw(l, idx_q[k], 8'($urandom));
		end
		check_all();
		pin_chk();
		foreach (cq[k]) begin
			cv[k] = $urandom & 8'hFF;
			i_pcfg_host.reg_wr(cq[k], 8'(cv[k]));
		end
		// Frozen clock enable drops the write
		clk_en = 1'b0;
		i_pcfg_host.reg_wr(8'h21, 8'(~cv[1]));
		clk_en = 1'b1;
		i_pcfg_host.reg_wr(8'h02, 8'h01);
		mdl_rst(1'b0);
		i_pcfg_host.reg_rd(8'h07, d);
		chk_reg("device number", 8'h00, d);
		foreach (cq[k]) begin
			i_pcfg_host.reg_rd(cq[k], d);
			chk_reg("card reg", 8'(cv[k]), d);
		end
		check_all();
		// Card number cleared by its own control bit
		i_pcfg_host.reg_wr(8'h06, 8'hC3);
		i_pcfg_host.reg_wr(8'h02, 8'h04);
		i_pcfg_host.reg_rd(8'h06, d);
		chk_reg("card number", 8'h00, d);
		pin_chk();
		mw(1, 8'h30, 8'h01);
		pin_chk();
		mw(0, 8'h71, 8'h00);
		pin_chk();
		mw(0, 8'h70, 8'h00);
		pin_chk();
		mw(0, 8'h30, 8'h00);
		mw(0, 8'h31, 8'h02);
		io_chk(16'h0060, 0, 1'b1);
		mw(0, 8'h31, 8'h03);
		io_chk(16'h0064, 0, 1'b1);
		io_chk(16'h0061, 0, 1'b0);
		mw(0, 8'h30, 8'h01);
		io_chk(16'h0060, 0, 1'b1);
		mw(2, 8'h30, 8'h00);
		mw(2, 8'h31, 8'h02);
		io_chk(16'h0071, 2, 1'b1);
		stop_test();
	end
endmodule // tb_pcfg_regs
